/* dv/serial_clock_gen_tb.sv */
// Self-checking bench for the serial transfer-clock generator
`timescale 1ns/1ps
module serial_clock_gen_tb;
   typedef struct {
      logic [1:0] mode;
      logic       dir;
      logic [1:0] src;
      logic [1:0] tap;
      logic       fe;
      logic [3:0] n;
      logic [3:0] k;
      int         ext;
      int         trig;
      int         period;
   } row_type;

   logic        clk_in, rst_in, pre_sel, pre_run;
   logic [5:0]  mode, tap, src;
   logic [2:0]  fe, dir, trig, peer_clk, pin, pin_out, pin_oe, basic, tick, par, wake, fast;
   logic [11:0] n, k;
   logic [15:0] ext_period, trig_period;
   int          n_fail;
   int          check_count;

   // ------------------------------------------------------------------
   // Cases: mode dir src tap fe n k ext trig bit period
   // ------------------------------------------------------------------
   row_type rows [14] = '{
      '{2'h2, 1'b0, 2'h0, 2'h0, 1'b0, 4'h1, 4'h0, 0, 0, 64},
      '{2'h1, 1'b0, 2'h0, 2'h1, 1'b0, 4'h2, 4'h0, 0, 0, 512},
      '{2'h3, 1'b0, 2'h0, 2'h2, 1'b0, 4'h1, 4'h0, 0, 0, 1024},
      '{2'h2, 1'b0, 2'h0, 2'h3, 1'b0, 4'h1, 4'h0, 0, 0, 4096},
      '{2'h2, 1'b0, 2'h0, 2'h0, 1'b0, 4'h0, 4'h0, 0, 0, 1024},
      '{2'h1, 1'b0, 2'h0, 2'h0, 1'b1, 4'h2, 4'h8, 0, 0, 160},
      '{2'h2, 1'b0, 2'h0, 2'h0, 1'b1, 4'hf, 4'hf, 0, 0, 964},
      '{2'h0, 1'b0, 2'h0, 2'h0, 1'b0, 4'h3, 4'h0, 0, 0, 24},
      '{2'h0, 1'b0, 2'h0, 2'h0, 1'b1, 4'h3, 4'h8, 0, 0, 24},
      '{2'h3, 1'b0, 2'h1, 2'h0, 1'b0, 4'h1, 4'h0, 0, 0, 16},
      '{2'h2, 1'b0, 2'h2, 2'h0, 1'b0, 4'h1, 4'h0, 0, 5, 80},
      '{2'h1, 1'b0, 2'h3, 2'h0, 1'b0, 4'h1, 4'h0, 4, 0, 64},
      '{2'h0, 1'b1, 2'h0, 2'h0, 1'b0, 4'h1, 4'h0, 16, 0, 16},
      '{2'h0, 1'b1, 2'h2, 2'h0, 1'b0, 4'h1, 4'h0, 20, 5, 20}
   };

   assign pin = (pin_oe & pin_out) | (~pin_oe & peer_clk);

   serial_clock_gen i_serial_clock_gen (
      .clk_in                      (clk_in),
      .rst_in                      (rst_in),
      .prescaler_input_select_in   (pre_sel),
      .serial_mode_in              (mode),
      .baud_input_select_in        (tap),
      .fractional_enable_in        (fe),
      .integer_divisor_in          (n),
      .fraction_value_in           (k),
      .uart_clock_source_select_in (src),
      .shift_clock_direction_in    (dir),
      .timer_trigger_clock_in      (trig),
      .serial_clock_pin_in         (pin),
      .serial_clock_pin_out        (pin_out),
      .serial_clock_pin_oe_out     (pin_oe),
      .serial_basic_clock_out      (basic),
      .bit_tick_out                (tick),
      .parity_allowed_out          (par),
      .wakeup_allowed_out          (wake),
      .ext_clock_too_fast_out      (fast),
      .prescaler_running_out       (pre_run)
   );

   serial_peer i_serial_peer (
      .clk_in         (clk_in),
      .rst_in         (rst_in),
      .ext_period_in  (ext_period),
      .trig_period_in (trig_period),
      .ext_clock_out  (peer_clk),
      .trigger_out    (trig)
   );

   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic test_done();
      if (n_fail == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : test_done

   task automatic reset_check();
      rst_in <= 1'b1;
      repeat (10) @(posedge clk_in);
      check(pin_out, 3'h7);
      check({basic, tick, par, wake, fast, pre_run}, 16'h0);
      rst_in <= 1'b0;
   endtask : reset_check

   // Idle in shift mode with an input clock so every counter restarts from zero, except the gap counter, which saturates at GAP_MAX
   task automatic apply(input row_type r);
      @(posedge clk_in);
      src <= 6'h15;
      mode <= 6'h00;
      dir <= 3'h7;
      ext_period <= 16'h0;
      trig_period <= 16'h0;
      repeat (10) @(posedge clk_in);
      mode <= {3{r.mode}};
      dir <= {3{r.dir}};
      src <= {3{r.src}};
      tap <= {3{r.tap}};
      fe <= {3{r.fe}};
      n <= {3{r.n}};
      k <= {3{r.k}};
      ext_period <= r.ext[15:0];
      trig_period <= r.trig[15:0];
   endtask : apply

   task automatic measure(input row_type r);
      int c;
      int b;
      int f;
      int d;
      int s;
      c = 0;
      while (tick[0] !== 1'b1 && c < 10000) begin
         @(posedge clk_in);
         c++;
      end
      c = 0;
      b = 0;
      f = 0;
      d = 0;
      s = 0;
      do begin
         @(posedge clk_in);
         c++;
         b += int'(basic[0] === 1'b1);
         f += int'(fast !== 3'h0);
         d += int'(tick !== {3{tick[0]}});
         s += int'(pin_out[0] === 1'b0);
      end while (tick[0] !== 1'b1 && c < 10000);
      check(c, r.period);
      check(b, (r.mode != 2'h0) ? 16 : 0);
      check(f, 0);
      check(d, 0);
      check(s, (r.mode == 2'h0 && !r.dir) ? r.period / 2 : 0);
      check(par, {3{r.mode == 2'h1 || r.mode == 2'h2}});
      check(wake, {3{r.mode == 2'h3}});
      check(pin_oe, {3{r.mode == 2'h0 && !r.dir}});
      check(pre_run, (r.mode != 2'h0 && r.src == 2'h0) || (r.mode == 2'h0 && !r.dir));
   endtask : measure

   // A clock whose phases last one cycle never passes the pin synchroniser
   task automatic fast_test(input row_type r, input int p, input logic exp_fast);
      int f;
      int b;
      r.ext = p;
      apply(r);
      f = 0;
      b = 0;
      repeat (60) begin
         @(posedge clk_in);
         f += int'(fast[0] === 1'b1);
         b += int'(basic[0] === 1'b1);
      end
      check(f > 0, exp_fast);
      check(b, 0);
   endtask : fast_test

   initial begin
      int t;
      rst_in = 1'b1;
      pre_sel = 1'b0;
      mode = 6'h2a;
      tap = 6'h0;
      src = 6'h15;
      fe = 3'h0;
      dir = 3'h0;
      n = 12'h111;
      k = 12'h0;
      ext_period = 16'h0;
      trig_period = 16'h0;
      n_fail = 0;
      check_count = 0;
      reset_check();
      foreach (rows[i]) begin
         apply(rows[i]);
         measure(rows[i]);
      end
      // Select bit set: prescaler must stay stopped
      apply(rows[0]);
      pre_sel <= 1'b1;
      t = 0;
      repeat (300) begin
         @(posedge clk_in);
         t += int'(tick !== 3'h0);
      end
      check(t, 0);
      check(pre_run, 0);
      pre_sel <= 1'b0;
      fast_test(rows[11], 2, 1'b0);
      fast_test(rows[12], 8, 1'b1);
      apply(rows[7]);
      repeat (50) @(posedge clk_in);
      reset_check();
      measure(rows[7]);
      test_done();
   end

   initial begin
      #200000;
      n_fail++;
      test_done();
   end
endmodule : serial_clock_gen_tb

/* dv/serial_peer.sv */
// Behavioural serial peer: external shift clock and timer trigger pulses
`timescale 1ns/1ps
module serial_peer (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic [15:0] ext_period_in,
   input  wire logic [15:0] trig_period_in,
   output logic      [2:0]  ext_clock_out,
   output logic      [2:0]  trigger_out
);
   int ec;
   int tc;

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         ec <= 0;
         tc <= 0;
         ext_clock_out <= 3'h7;
         trigger_out <= 3'h0;
      end else begin
         // Clock stands high while no frame is running
         if (ext_period_in == 16'h0) begin
            ec <= 0;
            ext_clock_out <= 3'h7;
         end else begin
            ec <= (ec + 1 >= int'(ext_period_in)) ? 0 : ec + 1;
            ext_clock_out <= {3{ec < int'(ext_period_in) / 2}};
         end
         tc <= (tc + 1 >= int'(trig_period_in)) ? 0 : tc + 1;
         trigger_out <= {3{trig_period_in != 16'h0 && tc == 0}};
      end
   end
endmodule : serial_peer

/* hw/pin_edge_sync.sv */
// Three-stage pin synchroniser with a debounced level and a rising-edge pulse
`timescale 1ns/1ps
module pin_edge_sync (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic async_in,
   output logic      level_out,
   output logic      rise_out
);
   logic [2:0] stage_q;
   logic [2:0] stage_d;
   logic       level_q;
   logic       level_d;
   logic       rise_q;
   logic       rise_d;

   always_comb begin
      stage_d = {stage_q[1:0], async_in};
      level_d = level_q;
      rise_d  = 1'b0;
      // A change counts once the second and third stages agree
      if (stage_q[1] == stage_q[2] && stage_q[2] != level_q) begin
         level_d = stage_q[2];
         rise_d  = stage_q[2];
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         // Pin idles high, so start there to avoid a false edge after reset
         stage_q <= 3'h7;
         level_q <= 1'b1;
         rise_q  <= 1'b0;
      end else begin
         stage_q <= stage_d;
         level_q <= level_d;
         rise_q  <= rise_d;
      end
   end

   assign level_out = level_q;
   assign rise_out  = rise_q;
endmodule : pin_edge_sync

/* hw/serial_clock_gen.sv */
// Shared prescaler and per-channel baud, basic and bit clock generation
`timescale 1ns/1ps
module serial_clock_gen #(
   parameter int CHANNELS = 3
) (
   input  wire logic                  clk_in,
   input  wire logic                  rst_in,
   input  wire logic                  prescaler_input_select_in,
   input  wire logic [2*CHANNELS-1:0] serial_mode_in,
   input  wire logic [2*CHANNELS-1:0] baud_input_select_in,
   input  wire logic [CHANNELS-1:0]   fractional_enable_in,
   input  wire logic [4*CHANNELS-1:0] integer_divisor_in,
   input  wire logic [4*CHANNELS-1:0] fraction_value_in,
   input  wire logic [2*CHANNELS-1:0] uart_clock_source_select_in,
   input  wire logic [CHANNELS-1:0]   shift_clock_direction_in,
   input  wire logic [CHANNELS-1:0]   timer_trigger_clock_in,
   input  wire logic [CHANNELS-1:0]   serial_clock_pin_in,
   output logic      [CHANNELS-1:0]   serial_clock_pin_out,
   output logic      [CHANNELS-1:0]   serial_clock_pin_oe_out,
   output logic      [CHANNELS-1:0]   serial_basic_clock_out,
   output logic      [CHANNELS-1:0]   bit_tick_out,
   output logic      [CHANNELS-1:0]   parity_allowed_out,
   output logic      [CHANNELS-1:0]   wakeup_allowed_out,
   output logic      [CHANNELS-1:0]   ext_clock_too_fast_out,
   output logic                       prescaler_running_out
);
   // ------------------------------------------------------------------
   // Shared prescaler
   // ------------------------------------------------------------------
   logic [CHANNELS-1:0]             uses_baud_gen;
   logic                            pre_run;
   logic [serial_clock_pkg::PRE_STAGE_WIDTH-1:0] pre_stage_q;
   logic [serial_clock_pkg::PRE_STAGE_WIDTH-1:0] pre_stage_d;
   logic [serial_clock_pkg::PRESCALER_WIDTH-1:0] pre_cnt_q;
   logic [serial_clock_pkg::PRESCALER_WIDTH-1:0] pre_cnt_d;
   logic                            pre_run_q;
   logic [3:0]                      taps;

   assign pre_run = (|uses_baud_gen) && !prescaler_input_select_in;

   always_comb begin
      pre_stage_d = '0;
      pre_cnt_d   = '0;
      if (pre_run) begin
         pre_stage_d = pre_stage_q + 2'h1;
         pre_cnt_d   = pre_cnt_q;
         if (pre_stage_q == serial_clock_pkg::PRE_STAGE_LAST) begin
            pre_cnt_d = pre_cnt_q + 6'h01;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         pre_stage_q <= '0;
         pre_cnt_q   <= '0;
         pre_run_q   <= 1'b0;
      end else begin
         pre_stage_q <= pre_stage_d;
         pre_cnt_q   <= pre_cnt_d;
         pre_run_q   <= pre_run;
      end
   end

   // Tap pulses every 4, 16, 64 and 256 source cycles
   always_comb begin
      taps[0] = pre_run && pre_stage_q == serial_clock_pkg::PRE_STAGE_LAST;
      taps[1] = taps[0] && (pre_cnt_q & serial_clock_pkg::PRE_DIV16_MASK)
                == serial_clock_pkg::PRE_DIV16_MASK;
      taps[2] = taps[0] && (pre_cnt_q & serial_clock_pkg::PRE_DIV64_MASK)
                == serial_clock_pkg::PRE_DIV64_MASK;
      taps[3] = taps[0] && pre_cnt_q == serial_clock_pkg::PRE_DIV256_MASK;
   end

   assign prescaler_running_out = pre_run_q;

   a_pre_idle: assert property (@(posedge clk_in) disable iff (rst_in)
      !pre_run |=> (pre_cnt_q == '0 && !taps[0]))
      else $error("prescaler advanced while no channel used the generator");
   a_tap_nesting: assert property (@(posedge clk_in) disable iff (rst_in)
      taps[3] |-> (taps[2] && taps[1] && taps[0]))
      else $error("slow prescaler tap not aligned to faster taps");
   a_tap4_spacing: assert property (@(posedge clk_in) disable iff (rst_in)
      taps[0] |=> !taps[0] [*3])
      else $error("divide-by-4 tap pulsed too often");

   // ------------------------------------------------------------------
   // Channels
   // ------------------------------------------------------------------
   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      serial_clock_pkg::serial_mode_type mode;
      logic       sync_mode;
      logic       dir_input;
      logic [1:0] src_sel;
      logic [3:0] div_field;
      logic [3:0] frac_field;
      logic       frac_on;
      logic       tap_sel;
      logic       ext_level;
      logic       ext_rise;
      logic [4:0] n_val;
      logic [4:0] frac_sum;
      logic       extra;
      logic [4:0] period;
      logic       bg_tick;
      logic       basic;
      logic [4:0] bg_cnt_q,  bg_cnt_d;
      logic [3:0] acc_q,     acc_d;
      logic [3:0] os_cnt_q,  os_cnt_d;
      logic       sclk_q,    sclk_d;
      logic       bit_q,     bit_d;
      logic       basic_q;
      logic [4:0] gap_q,     gap_d;
      logic       fast_q,    fast_d;
      logic       parity_q,  wake_q;

      assign mode       = serial_clock_pkg::serial_mode_type'(serial_mode_in[2*ch +: 2]);
      assign sync_mode  = mode == serial_clock_pkg::MODE_SYNC_SHIFT;
      assign dir_input  = shift_clock_direction_in[ch];
      assign src_sel    = uart_clock_source_select_in[2*ch +: 2];
      assign div_field  = integer_divisor_in[4*ch +: 4];
      assign frac_field = fraction_value_in[4*ch +: 4];
      assign frac_on    = fractional_enable_in[ch] && !sync_mode;
      assign tap_sel    = taps[baud_input_select_in[2*ch +: 2]];

      assign uses_baud_gen[ch] = sync_mode ? !dir_input
                               : src_sel == serial_clock_pkg::SRC_BAUD_GEN;

      pin_edge_sync u_ext_sync (
         .clk_in   (clk_in),
         .rst_in   (rst_in),
         .async_in (serial_clock_pin_in[ch]),
         .level_out(ext_level),
         .rise_out (ext_rise)
      );

      // Divider: N ticks per output, one more whenever the fraction carries in a UART mode
      always_comb begin
         n_val = (div_field == serial_clock_pkg::DIVISOR_AS_16)
               ? serial_clock_pkg::DIVISOR_MAX : {1'b0, div_field};
         frac_sum = {1'b0, acc_q}
                  + (serial_clock_pkg::FRACTION_ONE - {1'b0, frac_field});
         extra    = frac_on && frac_sum[4];
         period   = n_val + {4'h0, extra};
         bg_tick  = tap_sel && (bg_cnt_q == period - serial_clock_pkg::COUNT_ONE);
         bg_cnt_d = bg_cnt_q;
         acc_d    = acc_q;
         if (!uses_baud_gen[ch]) begin
            bg_cnt_d = '0;
            acc_d    = '0;
         end else if (bg_tick) begin
            bg_cnt_d = '0;
            if (frac_on) begin
               acc_d = frac_sum[3:0];
            end
         end else if (tap_sel) begin
            bg_cnt_d = bg_cnt_q + serial_clock_pkg::COUNT_ONE;
         end
      end

      // UART basic clock source; the timer is never a shift-mode source
      always_comb begin
         case (src_sel)
            serial_clock_pkg::SRC_BAUD_GEN: basic = bg_tick;
            serial_clock_pkg::SRC_SYSTEM:   basic = 1'b1;
            serial_clock_pkg::SRC_TIMER:    basic = timer_trigger_clock_in[ch];
            serial_clock_pkg::SRC_EXT_PIN:  basic = ext_rise;
            default:                        basic = 1'b0;
         endcase
         if (sync_mode) begin
            basic = 1'b0;
         end
      end

      // Bit timing: 16 basic clocks per UART bit, two generator ticks per driven shift bit, one external rising edge per input-clock shift bit
      always_comb begin
         os_cnt_d = os_cnt_q;
         sclk_d   = sclk_q;
         bit_d    = 1'b0;
         if (!sync_mode) begin
            sclk_d = 1'b1;
            if (basic) begin
               os_cnt_d = os_cnt_q + serial_clock_pkg::OVERSAMPLE_ONE;
               bit_d    = os_cnt_q == serial_clock_pkg::OVERSAMPLE_LAST;
            end
         end else if (!dir_input) begin
            os_cnt_d = '0;
            if (bg_tick) begin
               sclk_d = !sclk_q;
               bit_d  = sclk_q;
            end
         end else begin
            os_cnt_d = '0;
            sclk_d   = 1'b1;
            bit_d    = ext_rise;
         end
      end

      // External clock period check in system clock cycles
      always_comb begin
         gap_d  = (gap_q == serial_clock_pkg::GAP_MAX) ? gap_q
                : gap_q + serial_clock_pkg::COUNT_ONE;
         fast_d = 1'b0;
         if (ext_rise) begin
            gap_d  = '0;
            fast_d = gap_q < ((sync_mode ? serial_clock_pkg::EXT_MIN_SYNC
                   : serial_clock_pkg::EXT_MIN_UART) - serial_clock_pkg::COUNT_ONE);
         end
      end

      always_ff @(posedge clk_in or posedge rst_in) begin
         if (rst_in) begin
            bg_cnt_q <= '0;
            acc_q    <= '0;
            os_cnt_q <= '0;
            sclk_q   <= 1'b1;
            bit_q    <= 1'b0;
            basic_q  <= 1'b0;
            gap_q    <= serial_clock_pkg::GAP_MAX;
            fast_q   <= 1'b0;
            parity_q <= 1'b0;
            wake_q   <= 1'b0;
         end else begin
            bg_cnt_q <= bg_cnt_d;
            acc_q    <= acc_d;
            os_cnt_q <= os_cnt_d;
            sclk_q   <= sclk_d;
            bit_q    <= bit_d;
            basic_q  <= basic;
            gap_q    <= gap_d;
            fast_q   <= fast_d;
            parity_q <= mode == serial_clock_pkg::MODE_UART_7BIT
                     || mode == serial_clock_pkg::MODE_UART_8BIT;
            wake_q   <= mode == serial_clock_pkg::MODE_UART_9BIT;
         end
      end

      assign serial_clock_pin_out[ch]    = sclk_q;
      assign serial_clock_pin_oe_out[ch] = sync_mode && !dir_input;
      assign serial_basic_clock_out[ch]  = basic_q;
      assign bit_tick_out[ch]            = bit_q;
      assign parity_allowed_out[ch]      = parity_q;
      assign wakeup_allowed_out[ch]      = wake_q;
      assign ext_clock_too_fast_out[ch]  = fast_q;

      a_int_divide: assert property (@(posedge clk_in) disable iff (rst_in)
         (bg_tick && !frac_on) |-> bg_cnt_q == n_val - serial_clock_pkg::COUNT_ONE)
         else $error("integer divider fired at wrong count");
      a_div_zero: assert property (@(posedge clk_in) disable iff (rst_in)
         (div_field == serial_clock_pkg::DIVISOR_AS_16 && bg_tick && !frac_on)
         |-> bg_cnt_q == 5'h0f)
         else $error("divisor field zero did not divide by 16");
      a_uart_wrap: assert property (@(posedge clk_in) disable iff (rst_in)
         (!sync_mode && basic && os_cnt_q == serial_clock_pkg::OVERSAMPLE_LAST)
         |=> (bit_q && os_cnt_q == 4'h0))
         else $error("UART bit tick missing after 16 basic clocks");
      a_uart_no_early: assert property (@(posedge clk_in) disable iff (rst_in)
         (!sync_mode && $past(!sync_mode) && bit_q) |-> $past(basic))
         else $error("UART bit tick without a basic clock");
      a_shift_half: assert property (@(posedge clk_in) disable iff (rst_in)
         (sync_mode && !dir_input && bg_tick) |=> sclk_q != $past(sclk_q))
         else $error("driven shift clock failed to toggle");
      a_ext_shift: assert property (@(posedge clk_in) disable iff (rst_in)
         (sync_mode && dir_input && ext_rise) |=> bit_q)
         else $error("external shift clock edge gave no bit tick");
      a_timer_src: assert property (@(posedge clk_in) disable iff (rst_in)
         (!sync_mode && src_sel == serial_clock_pkg::SRC_TIMER
          && timer_trigger_clock_in[ch]) |=> basic_q)
         else $error("timer trigger did not reach the basic clock");
      a_sync_no_basic: assert property (@(posedge clk_in) disable iff (rst_in)
         sync_mode |=> !basic_q)
         else $error("basic clock ran in shift mode");
   end

endmodule : serial_clock_gen

/* hw/serial_clock_pkg.sv */
// Constants and types shared by the serial transfer-clock generator
package serial_clock_pkg;

   // ------------------------------------------------------------------
   // Channel modes
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_SYNC_SHIFT = 2'b00,
      MODE_UART_7BIT  = 2'b01,
      MODE_UART_8BIT  = 2'b10,
      MODE_UART_9BIT  = 2'b11
   } serial_mode_type;

   // ------------------------------------------------------------------
   // Prescaler and baud generator
   // ------------------------------------------------------------------
   localparam int          PRESCALER_WIDTH = 6;
   localparam int          PRE_STAGE_WIDTH = 2;
   localparam logic [1:0]  PRE_STAGE_LAST  = 2'h3;
   localparam logic [5:0]  PRE_DIV16_MASK  = 6'h03;
   localparam logic [5:0]  PRE_DIV64_MASK  = 6'h0f;
   localparam logic [5:0]  PRE_DIV256_MASK = 6'h3f;
   localparam logic [1:0]  TAP_DIV4        = 2'h0;
   localparam logic [1:0]  TAP_DIV16       = 2'h1;
   localparam logic [1:0]  TAP_DIV64       = 2'h2;
   localparam logic [1:0]  TAP_DIV256      = 2'h3;
   localparam int          DIVISOR_WIDTH   = 4;
   localparam logic [3:0]  DIVISOR_AS_16   = 4'h0;
   localparam logic [4:0]  DIVISOR_MAX     = 5'h10;
   localparam logic [4:0]  FRACTION_ONE    = 5'h10;
   localparam logic [4:0]  COUNT_ONE       = 5'h01;

   // ------------------------------------------------------------------
   // Basic clock sources in UART mode
   // ------------------------------------------------------------------
   localparam logic [1:0]  SRC_BAUD_GEN    = 2'h0;
   localparam logic [1:0]  SRC_SYSTEM      = 2'h1;
   localparam logic [1:0]  SRC_TIMER       = 2'h2;
   localparam logic [1:0]  SRC_EXT_PIN     = 2'h3;

   // ------------------------------------------------------------------
   // Bit timing
   // ------------------------------------------------------------------
   localparam logic [3:0]  OVERSAMPLE_LAST = 4'hf;
   localparam logic [3:0]  OVERSAMPLE_ONE  = 4'h1;
   localparam logic [4:0]  EXT_MIN_UART    = 5'h04;
   localparam logic [4:0]  EXT_MIN_SYNC    = 5'h10;
   localparam logic [4:0]  GAP_MAX         = 5'h1f;

endpackage : serial_clock_pkg
